// File: ldr_regs.sv
// Loop diagnostic status tail and low-level configuration register.
// Assumes decoded SPI register accesses and status updates synchronous to I_SYS_CLK.
// Functional notes
// - Status bit 5 reports short to battery found by leakage test.
// - Status bit 4 reports leakage pin: 0 low side, 1 high side.
// - Status bits 3:0 report leakage channel; 1000-1111 mean none.
// - Status cleared by I_SRST or safing reset; else written only by diagnostic machine.
// - Config bit 15 selects low or high diagnostic layout.
// - Config bit 14 selects source magnitude: 0 is 40 mA, 1 is 8 mA.
// - Pull-down policy 0: off only on monitor, sink, source or bypass channels; route code 11 keeps it on at the leakage channel.
// - Pull-down policy 1: pull-down off on every channel.
// - Source code 00 off; 01 on at magnitude on resistance channel.
// - Source code 10 enables bypass current on resistance channel only.
// - Source code 11 enables source on resistance channel and amplifier on pair partner.
// - Config bit 10 enables sink on resistance channel only.
// - Config resets to zero; else changes only on host write.
// - Bits 9:8 route regulator current monitor to leakage channel pins.
// - Bits 7:4 select resistance and full-path test channel.
// - Bits 3:0 select leakage and transistor test channel.
`timescale 1ns/1ns
module ldr_regs
  import ldr_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic i_por_rst,
  input wire logic i_wdog_rst,
  input wire logic i_safing_machine_reset,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [CFG_W-1:0] i_wr_data,
  input wire logic i_stat_wr,
  input wire logic i_short_to_battery_flag,
  input wire logic i_leak_pin_indicator,
  input wire logic [3:0] i_leakage_channel_select,
  output logic [CFG_W-1:0] o_loop_diag_low_level_config,
  output logic [5:0] o_status,
  output logic o_diagnostic_depth_select,
  output logic o_source_magnitude_select,
  output logic [CH_N-1:0] o_source_en,
  output logic [CH_N-1:0] o_bypass_en,
  output logic [CH_N-1:0] o_sink_en,
  output logic [CH_N-1:0] o_diff_amp_sel,
  output logic [CH_N-1:0] o_pulldown_off,
  output logic [CH_N-1:0] o_regulator_current_monitor_route_high_pin,
  output logic [CH_N-1:0] o_regulator_current_monitor_route_low_pin,
  output logic [CH_N-1:0] o_leak_mux_sel,
  output logic [CH_N-1:0] o_res_mux_sel
);
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [5:0] stat_reg, stat_next;
  logic [CH_N-1:0] src_reg, src_next, byp_reg, byp_next, snk_reg, snk_next;
  logic [CH_N-1:0] amp_reg, amp_next, pd_reg, pd_next, vh_reg, vh_next;
  logic [CH_N-1:0] vl_reg, vl_next, lm_reg, lm_next, rm_reg, rm_next;
  logic any_rst;
  logic [1:0] src_mode, regulator_current_monitor_route_mode;
  logic [3:0] rch, lch;
  logic rch_ok, lch_ok;

  assign any_rst = I_SRST | i_por_rst | i_wdog_rst | i_safing_machine_reset;
  assign src_mode = cfg_reg[SRC_HI:SRC_LO];
  assign regulator_current_monitor_route_mode = cfg_reg[REGULATOR_CURRENT_MONITOR_ROUTE_HI:REGULATOR_CURRENT_MONITOR_ROUTE_LO];
  assign rch = cfg_reg[RCH_HI:RCH_LO];
  assign lch = cfg_reg[LCH_HI:LCH_LO];
  assign rch_ok = (rch <= CH_MAX);
  assign lch_ok = (lch <= CH_MAX);

  always_comb begin
    cfg_next = cfg_reg;
    stat_next = stat_reg;
    if (i_wr_en && (i_wr_addr == CFG_ADDR)) begin
      cfg_next = i_wr_data;
    end
    if (i_stat_wr) begin
      stat_next = {i_short_to_battery_flag, i_leak_pin_indicator, i_leakage_channel_select};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (any_rst) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
    if (I_SRST | i_safing_machine_reset) begin
      stat_reg <= STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      logic r_hit, l_hit, partner;
      assign r_hit = rch_ok && (rch[2:0] == 3'(g));
      assign l_hit = lch_ok && (lch[2:0] == 3'(g));
      assign partner = rch_ok && (rch[2:0] == 3'(g ^ 1));
      always_comb begin
        src_next[g] = r_hit && ((src_mode == SRC_ON) || (src_mode == SRC_ON_AMP));
        byp_next[g] = r_hit && (src_mode == SRC_BYPASS);
        amp_next[g] = partner && (src_mode == SRC_ON_AMP);
        snk_next[g] = r_hit && cfg_reg[SINK_BIT];
        vh_next[g] = l_hit && (regulator_current_monitor_route_mode == REGULATOR_CURRENT_MONITOR_ROUTE_HIGH);
        vl_next[g] = l_hit && ((regulator_current_monitor_route_mode == REGULATOR_CURRENT_MONITOR_ROUTE_LOW_PDOFF) || (regulator_current_monitor_route_mode == REGULATOR_CURRENT_MONITOR_ROUTE_LOW_PDON));
        lm_next[g] = l_hit;
        rm_next[g] = r_hit;
        if (cfg_reg[PD_BIT]) begin
          pd_next[g] = 1'b1;
        end else if (l_hit && (regulator_current_monitor_route_mode == REGULATOR_CURRENT_MONITOR_ROUTE_LOW_PDON)) begin
          pd_next[g] = 1'b0;
        end else begin
          pd_next[g] = src_next[g] | byp_next[g] | snk_next[g] | vh_next[g] | vl_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK) begin
    if (any_rst) begin
      src_reg <= '0;
      byp_reg <= '0;
      snk_reg <= '0;
      amp_reg <= '0;
      pd_reg <= '0;
      vh_reg <= '0;
      vl_reg <= '0;
      lm_reg <= '0;
      rm_reg <= '0;
    end else begin
      src_reg <= src_next;
      byp_reg <= byp_next;
      snk_reg <= snk_next;
      amp_reg <= amp_next;
      pd_reg <= pd_next;
      vh_reg <= vh_next;
      vl_reg <= vl_next;
      lm_reg <= lm_next;
      rm_reg <= rm_next;
    end
  end

  assign o_loop_diag_low_level_config = cfg_reg;
  assign o_status = stat_reg;
  assign o_diagnostic_depth_select = cfg_reg[LEVEL_BIT];
  assign o_source_magnitude_select = cfg_reg[MAG_BIT];
  assign o_source_en = src_reg;
  assign o_bypass_en = byp_reg;
  assign o_sink_en = snk_reg;
  assign o_diff_amp_sel = amp_reg;
  assign o_pulldown_off = pd_reg;
  assign o_regulator_current_monitor_route_high_pin = vh_reg;
  assign o_regulator_current_monitor_route_low_pin = vl_reg;
  assign o_leak_mux_sel = lm_reg;
  assign o_res_mux_sel = rm_reg;
endmodule : ldr_regs

// File: ldr_pkg.sv
// Package for loop diagnostic low-level register logic.
// Assumes an external SPI frame decoder and a loop diagnostic state machine.
package ldr_pkg;
  localparam int CFG_W = 20;
  localparam logic [7:0] CFG_ADDR = 8'h38;
  localparam int CH_N = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;
  localparam int LEVEL_BIT = 15;
  localparam int MAG_BIT = 14;
  localparam int PD_BIT = 13;
  localparam int SRC_HI = 12;
  localparam int SRC_LO = 11;
  localparam int SINK_BIT = 10;
  localparam int REGULATOR_CURRENT_MONITOR_ROUTE_HI = 9;
  localparam int REGULATOR_CURRENT_MONITOR_ROUTE_LO = 8;
  localparam int RCH_HI = 7;
  localparam int RCH_LO = 4;
  localparam int LCH_HI = 3;
  localparam int LCH_LO = 0;
  localparam int STB_BIT = 5;
  localparam int PIN_BIT = 4;
  localparam logic [5:0] STAT_RESET = 6'h00;
  localparam logic [3:0] CH_MAX = 4'h7;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_ON = 2'h1;
  localparam logic [1:0] SRC_BYPASS = 2'h2;
  localparam logic [1:0] SRC_ON_AMP = 2'h3;
  localparam logic [1:0] REGULATOR_CURRENT_MONITOR_ROUTE_NONE = 2'h0;
  localparam logic [1:0] REGULATOR_CURRENT_MONITOR_ROUTE_HIGH = 2'h1;
  localparam logic [1:0] REGULATOR_CURRENT_MONITOR_ROUTE_LOW_PDOFF = 2'h2;
  localparam logic [1:0] REGULATOR_CURRENT_MONITOR_ROUTE_LOW_PDON = 2'h3;
endpackage : ldr_pkg

// File: ldr_monitor.sv
// Checker for ldr_regs port behaviour.
// Assumes binding to ldr_regs, shown below the module.
`timescale 1ns/1ns
module ldr_monitor (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic i_por_rst,
  input wire logic i_wdog_rst,
  input wire logic i_safing_machine_reset,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [19:0] i_wr_data,
  input wire logic [19:0] o_loop_diag_low_level_config,
  input wire logic [5:0] o_status,
  input wire logic [7:0] o_source_en,
  input wire logic [7:0] o_bypass_en,
  input wire logic [7:0] o_sink_en,
  input wire logic [7:0] o_pulldown_off
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  wire r = i_por_rst | i_wdog_rst | i_safing_machine_reset;
  wire [19:0] c = o_loop_diag_low_level_config;
  wire w = i_wr_en && i_wr_addr == 8'h38 && !r;
  wire ok = !r && !c[7];
  sequence s_wr; w; endsequence
  a_cfg_write: assert property (s_wr |=> c == $past(i_wr_data)) else $error("cfg");
  a_cfg_hold: assert property (!r && !w |=> $stable(c)) else $error("hold");
  a_cfg_clear: assert property (r |=> c == 20'h00000) else $error("clr");
  a_stat_clear: assert property (i_safing_machine_reset |=> o_status == 6'h00) else $error("st");
  a_sink_chan: assert property (ok && c[10] |=> o_sink_en == 8'h01 << $past(c[6:4])) else $error("snk");
  a_bypass_chan: assert property (ok && c[12:11] == 2'h2 |=> o_bypass_en == 8'h01 << $past(c[6:4])
    && o_source_en == 8'h00) else $error("byp");
  a_no_range: assert property (!r && c[7] |=> (o_source_en | o_bypass_en | o_sink_en) == 8'h00) else $error("oor");
  a_pd_all: assert property (!r && c[13] |=> o_pulldown_off == 8'hFF) else $error("pd");
endmodule : ldr_monitor
bind ldr_regs ldr_monitor u_mon (.I_SYS_CLK, .I_SRST, .i_por_rst, .i_wdog_rst, .i_safing_machine_reset, .i_wr_en,
  .i_wr_addr, .i_wr_data, .o_loop_diag_low_level_config, .o_status, .o_source_en, .o_bypass_en, .o_sink_en,
  .o_pulldown_off);

// File: ldr_host.sv
// Host model issuing decoded register writes.
// Assumes writes are driven at the falling clock edge.
`timescale 1ns/1ns
module ldr_host (
  input wire logic i_clk,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [19:0] o_data
);
  initial {o_wr, o_addr, o_data} = 29'h0;
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(negedge i_clk) {o_wr, o_addr, o_data} = {1'b1, a, d};
    @(negedge i_clk) {o_wr, o_addr, o_data} = {1'b0, ~a, ~d};
  endtask : wr
endmodule : ldr_host

// File: loop_diag_lowlevel_regs_bench.sv
// Bench for ldr_regs: host writes, status loads, resets.
// Assumes ldr_host partner and the bound monitor.
`timescale 1ns/1ns
module loop_diag_lowlevel_regs_bench;
  import ldr_pkg::*;
  logic I_SYS_CLK = 0, I_SRST = 1, por = 0, wdg = 0, saf = 0, sw = 0, stb = 0, pin = 0, wr;
  logic [3:0] lch = 0;
  logic [7:0] ad, src, byp, snk, amp, pd, vh, vl, lm, rm;
  logic dep, mag;
  logic [19:0] wdat, cfg;
  logic [5:0] st;
  int failures = 0, checked = 0;
  always #4 I_SYS_CLK = ~I_SYS_CLK;
  ldr_host host (.i_clk(I_SYS_CLK), .o_wr(wr), .o_addr(ad), .o_data(wdat));
  ldr_regs dut (.I_SYS_CLK, .I_SRST, .i_por_rst(por), .i_wdog_rst(wdg), .i_safing_machine_reset(saf),
    .i_wr_en(wr), .i_wr_addr(ad), .i_wr_data(wdat), .i_stat_wr(sw), .i_short_to_battery_flag(stb),
    .i_leak_pin_indicator(pin), .i_leakage_channel_select(lch), .o_loop_diag_low_level_config(cfg),
    .o_status(st), .o_diagnostic_depth_select(dep), .o_source_magnitude_select(mag), .o_source_en(src),
    .o_bypass_en(byp), .o_sink_en(snk), .o_diff_amp_sel(amp), .o_pulldown_off(pd), .o_regulator_current_monitor_route_high_pin(vh),
    .o_regulator_current_monitor_route_low_pin(vl), .o_leak_mux_sel(lm), .o_res_mux_sel(rm));
  task automatic cmp(input string n, input logic [19:0] e, s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      host.wr(CFG_ADDR, 20'(20'h00424 | m << 11));
      @(negedge I_SYS_CLK);
      cmp("cfg", 20'(20'h00424 | m << 11), cfg);
      cmp("src", m[0] ? 8'h04 : 8'h00, src);
      cmp("byp", m == 2 ? 8'h04 : 8'h00, byp);
      cmp("amp", m == 3 ? 8'h08 : 8'h00, amp);
      cmp("snk", 8'h04, snk);
    end
    $display("modes done");
  endtask : t_modes
  task automatic t_route;
    for (int v = 1; v < 4; v++) begin
      host.wr(CFG_ADDR, 20'(20'h0C053 | v << 8));
      @(negedge I_SYS_CLK);
      cmp("dep", 20'h1, dep);
      cmp("mag", 20'h1, mag);
      cmp("vh", v == 1 ? 8'h08 : 8'h00, vh);
      cmp("vl", v > 1 ? 8'h08 : 8'h00, vl);
      cmp("pd", v == 3 ? 8'h00 : 8'h08, pd);
      cmp("lm", 8'h08, lm);
      cmp("rm", 8'h20, rm);
    end
    $display("route done");
  endtask : t_route
  task automatic t_limits;
    host.wr(CFG_ADDR, 20'h02C80);
    host.wr(8'h39, 20'hFFFFF);
    cmp("cfg", 20'h02C80, cfg);
    cmp("cur", 8'h00, src | byp | snk);
    cmp("pd", 8'hFF, pd);
    $display("limits done");
  endtask : t_limits
  task automatic t_stat;
    @(negedge I_SYS_CLK) {sw, stb, pin, lch} = 7'h7C;
    @(negedge I_SYS_CLK) {sw, por} = 2'h1;
    @(negedge I_SYS_CLK) por = 0;
    cmp("st", 6'h3C, st);
    cmp("cfg", 20'h00000, cfg);
    saf = 1;
    @(negedge I_SYS_CLK) saf = 0;
    cmp("st", 6'h00, st);
    $display("status done");
  endtask : t_stat
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000 failures++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(negedge I_SYS_CLK);
    I_SRST = 0;
    cmp("rst", CFG_RESET, cfg);
    t_modes;
    t_route;
    t_limits;
    t_stat;
    tally_and_finish;
  end
endmodule : loop_diag_lowlevel_regs_bench
